// [design/adcc_regs.svh]
// Register offsets, field positions, reset values and counts of the converter control block
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

// Register byte offsets
`define ADCC_CTRL_FIRST_OFS   8'h00
`define ADCC_CTRL_SECOND_OFS  8'h04
`define ADCC_PIN_ENABLE_OFS   8'h08
`define ADCC_RESULT_OFS       8'h0C
`define ADCC_INT_STATUS_OFS   8'h10
`define ADCC_INT_MASK_OFS     8'h14

// converter_control_first fields
`define ADCC_START_BIT        7
`define ADCC_BUSY_BIT         6
`define ADCC_POWER_OFF_BIT    5
`define ADCC_JUSTIFY_BIT      4

// converter_control_second fields
`define ADCC_REF_SEL_BIT      4
`define ADCC_DIV_SEL_MSB      2
`define ADCC_DIV_SEL_LSB      0

// Interrupt status and mask field
`define ADCC_DONE_BIT         0

// Reset values
`define ADCC_START_RST        1'b0
`define ADCC_POWER_OFF_RST    1'b1
`define ADCC_JUSTIFY_RST      1'b0
`define ADCC_REF_SEL_RST      1'b0
`define ADCC_DIV_SEL_RST      3'h0
`define ADCC_PIN_ENABLE_RST   4'hF
`define ADCC_MASK_RST         1'b0

// Converter clock periods per conversion
`define ADCC_CONV_TICKS       5'h10

`endif

// [design/adcc_pkg.sv]
// Types shared by the converter control block
package adcc_pkg;

   typedef enum logic [1:0] {
      ADCC_IDLE,
      ADCC_HOLD,
      ADCC_CONV
   } adcc_state_t;

   typedef struct packed {
      logic       sar_reset;
      logic       conv_clk_tick;
      logic       power_en;
      logic       ref_external;
      logic       vref_pin_sel;
      logic [3:0] analog_input_enables;
   } adcc_ana_t;

endpackage

// [design/adcc_top.sv]
// APB-controlled conversion control for a 12-bit successive-approximation converter
`timescale 1ns/10ps
`include "adcc_regs.svh"

module adcc_top
(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               reset,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Converter analog side
   input  wire logic [11:0]        conv_code,
   output adcc_pkg::adcc_ana_t     ana,
   // Interrupt
   output logic                    irq
);

   // Division limit for the converter clock counter
   function automatic logic [5:0] div_limit(input logic [2:0] sel);
      logic [6:0] v;
      v = 7'h01;
      if (sel == 3'h7)
      begin
         v = 7'h40;
      end
      else
      begin
         v = 7'(7'h01 << sel);
      end
      return 6'(v - 7'h01);
   endfunction

   // Place the 12-bit code in the 16-bit result word
   function automatic logic [15:0] place_code(input logic [11:0] code,
                                              input logic        right);
      logic [15:0] w;
      w = {code, 4'h0};
      if (right)
      begin
         w = {4'h0, code};
      end
      return w;
   endfunction

   adcc_pkg::adcc_state_t state_q;
   adcc_pkg::adcc_ana_t   ana_q;

   logic        start_q;
   logic        power_off_q;
   logic        justify_q;
   logic        ref_sel_q;
   logic [2:0]  div_sel_q;
   logic [3:0]  pin_en_q;
   logic [11:0] code_q;
   logic [11:0] code_s1_q;
   logic [11:0] code_s2_q;
   logic        status_q;
   logic        mask_q;
   logic        irq_q;
   logic [5:0]  div_cnt_q;
   logic        tick_q;
   logic [4:0]  tick_cnt_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   logic        setup;
   logic        wr;
   logic        rd;
   logic        wr_ctrl1;
   logic        start_rise;
   logic        start_fall;
   logic        busy;
   logic        done;
   logic        rd_clr;
   logic [31:0] rd_word;
   logic        rd_hit;

   assign setup = psel & ~penable;
   assign wr    = psel & penable & pready_q & pwrite;
   assign rd    = psel & penable & pready_q & ~pwrite;

   assign wr_ctrl1   = wr & (paddr == `ADCC_CTRL_FIRST_OFS);
   assign start_rise = wr_ctrl1 & pwdata[`ADCC_START_BIT] & ~start_q;
   assign start_fall = wr_ctrl1 & ~pwdata[`ADCC_START_BIT] & start_q;

   // Busy while held in reset or converting
   assign busy = (state_q != adcc_pkg::ADCC_IDLE);
   assign done = (state_q == adcc_pkg::ADCC_CONV) & tick_q
               & (tick_cnt_q == 5'(`ADCC_CONV_TICKS - 5'h01));

   // Read clear only takes bits that the read actually returned
   assign rd_clr = rd & (paddr == `ADCC_INT_STATUS_OFS)
                 & prdata_q[`ADCC_DONE_BIT];

   // Read data selection
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (paddr)
         `ADCC_CTRL_FIRST_OFS:
         begin
            rd_word[`ADCC_START_BIT]     = start_q;
            rd_word[`ADCC_BUSY_BIT]      = busy;
            rd_word[`ADCC_POWER_OFF_BIT] = power_off_q;
            rd_word[`ADCC_JUSTIFY_BIT]   = justify_q;
         end
         `ADCC_CTRL_SECOND_OFS:
         begin
            rd_word[`ADCC_REF_SEL_BIT] = ref_sel_q;
            rd_word[`ADCC_DIV_SEL_MSB:`ADCC_DIV_SEL_LSB] = div_sel_q;
         end
         `ADCC_PIN_ENABLE_OFS:
         begin
            rd_word[3:0] = pin_en_q;
         end
         `ADCC_RESULT_OFS:
         begin
            rd_word[15:0] = place_code(code_q, justify_q);
         end
         `ADCC_INT_STATUS_OFS:
         begin
            rd_word[`ADCC_DONE_BIT] = status_q;
         end
         `ADCC_INT_MASK_OFS:
         begin
            rd_word[`ADCC_DONE_BIT] = mask_q;
         end
         default:
         begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // APB answer: no wait states, data and error captured in setup
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         pready_q  <= setup;
         if (setup)
         begin
            pslverr_q <= ~rd_hit;
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
         end
         else
         begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // Control register writes
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         start_q     <= `ADCC_START_RST;
         power_off_q <= `ADCC_POWER_OFF_RST;
         justify_q   <= `ADCC_JUSTIFY_RST;
         ref_sel_q   <= `ADCC_REF_SEL_RST;
         div_sel_q   <= `ADCC_DIV_SEL_RST;
         pin_en_q    <= `ADCC_PIN_ENABLE_RST;
         mask_q      <= `ADCC_MASK_RST;
      end
      else if (wr)
      begin
         unique case (paddr)
            `ADCC_CTRL_FIRST_OFS:
            begin
               start_q     <= pwdata[`ADCC_START_BIT];
               power_off_q <= pwdata[`ADCC_POWER_OFF_BIT];
               justify_q   <= pwdata[`ADCC_JUSTIFY_BIT];
            end
            `ADCC_CTRL_SECOND_OFS:
            begin
               ref_sel_q <= pwdata[`ADCC_REF_SEL_BIT];
               div_sel_q <= pwdata[`ADCC_DIV_SEL_MSB:`ADCC_DIV_SEL_LSB];
            end
            `ADCC_PIN_ENABLE_OFS:
            begin
               pin_en_q <= pwdata[3:0];
            end
            `ADCC_INT_MASK_OFS:
            begin
               mask_q <= pwdata[`ADCC_DONE_BIT];
            end
            default:
            begin
               mask_q <= mask_q;
            end
         endcase
      end
   end

   // Converter clock divider, realigned at each conversion start
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         div_cnt_q <= 6'h00;
         tick_q    <= 1'b0;
      end
      else if (start_fall)
      begin
         div_cnt_q <= 6'h00;
         tick_q    <= 1'b0;
      end
      else if (div_cnt_q >= div_limit(div_sel_q))
      begin
         div_cnt_q <= 6'h00;
         tick_q    <= 1'b1;
      end
      else
      begin
         div_cnt_q <= 6'(div_cnt_q + 6'h01);
         tick_q    <= 1'b0;
      end
   end

   // Conversion sequencing
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= adcc_pkg::ADCC_IDLE;
      end
      else if (start_rise)
      begin
         state_q <= adcc_pkg::ADCC_HOLD;
      end
      else if (start_fall)
      begin
         state_q <= adcc_pkg::ADCC_CONV;
      end
      else if (done)
      begin
         state_q <= adcc_pkg::ADCC_IDLE;
      end
   end

   // Converter clock periods counted during a conversion
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         tick_cnt_q <= 5'h00;
      end
      else if (start_fall)
      begin
         tick_cnt_q <= 5'h00;
      end
      else if ((state_q == adcc_pkg::ADCC_CONV) && tick_q)
      begin
         tick_cnt_q <= 5'(tick_cnt_q + 5'h01);
      end
   end

   // Converted code from the analog side, synchronised then captured
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         code_s1_q <= 12'h000;
         code_s2_q <= 12'h000;
         code_q    <= 12'h000;
      end
      else
      begin
         code_s1_q <= conv_code;
         code_s2_q <= code_s1_q;
         if (done)
         begin
            code_q <= code_s2_q;
         end
      end
   end

   // Completion flag: a new completion wins over a read clear
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         status_q <= 1'b0;
         irq_q    <= 1'b0;
      end
      else
      begin
         status_q <= (status_q & ~rd_clr) | done;
         irq_q    <= status_q & mask_q;
      end
   end

   // Analog side controls
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         ana_q <= '0;
      end
      else
      begin
         ana_q.sar_reset            <= (state_q == adcc_pkg::ADCC_HOLD);
         ana_q.conv_clk_tick        <= (state_q == adcc_pkg::ADCC_CONV) & tick_q;
         ana_q.power_en             <= ~power_off_q;
         ana_q.ref_external         <= ref_sel_q;
         ana_q.vref_pin_sel         <= ref_sel_q;
         ana_q.analog_input_enables <= pin_en_q;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign ana     = ana_q;
   assign irq     = irq_q;

endmodule // adcc_top

// [verif/adcc_top_checker.sv]
// Port assertions for the converter control block
`timescale 1ns/10ps
module adcc_top_checker
(
   // Clock and reset
   input wire logic                core_clk,
   input wire logic                reset,
   // Register bus
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   // Converter side and interrupt
   input wire adcc_pkg::adcc_ana_t ana,
   input wire logic                irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic       wr;
   logic [4:0] cnt_q;
   assign wr = psel && penable && pready && pwrite;
   // Converter ticks since the last hold
   always_ff @(posedge core_clk or posedge reset)
      if (reset)
         cnt_q <= 5'h0;
      else if (ana.sar_reset)
         cnt_q <= 5'h0;
      else if (ana.conv_clk_tick)
         cnt_q <= cnt_q + 5'h1;
   hold_tick_a:
      assert property (ana.sar_reset |-> !ana.conv_clk_tick) else $error("tick in hold");
   busy_hold_a:
      assert property (pready && !pwrite && paddr == 8'h00 && ana.sar_reset |-> prdata[6]) else $error("busy low");
   power_wr_a:
      assert property (wr && paddr == 8'h00 |-> ##2 ana.power_en == !$past(pwdata[5], 2)) else $error("power");
   ref_wr_a:
      assert property (wr && paddr == 8'h04 |-> ##2 ana.ref_external == $past(pwdata[4], 2)) else $error("ref");
   ref_pin_a:
      assert property (ana.vref_pin_sel == ana.ref_external) else $error("ref pin");
   pin_pwr_a:
      assert property (wr && paddr == 8'h08 |-> ##2 $stable(ana.power_en)
         && ana.analog_input_enables == $past(pwdata[3:0], 2)) else $error("pin power");
   irq_fall_a:
      assert property ($fell(irq) |-> $past(psel && penable, 2)) else $error("irq fall");
   tick_count_a:
      assert property (ana.conv_clk_tick |-> cnt_q < 5'h10) else $error("too many ticks");
   cover property (ana.sar_reset);
   cover property ($rose(irq));
   cover property (ana.conv_clk_tick && cnt_q == 5'hF);
endmodule // adcc_top_checker

bind adcc_top adcc_top_checker chk_i (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .ana, .irq);

// [verif/tb_top.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "adcc_regs.svh"
module tb_top;
   localparam logic [7:0] CF = `ADCC_CTRL_FIRST_OFS;
   localparam logic [7:0] CS = `ADCC_CTRL_SECOND_OFS;
   // Analog settling wait after power-on, a plain default
   localparam int         SETTLE_CYCLES = 50;
   logic                core_clk, reset, psel, penable, pwrite, pready, pslverr, irq, j, se;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [11:0]         conv_code;
   adcc_pkg::adcc_ana_t ana;
   int                  num_errors, compares, seed, n, w;
   adcc_top uut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_code(conv_code), .ana(ana), .irq(irq));
   task automatic summarize;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge core_clk);
         i++;
      end
      while (pready !== 1'b1 && i < 20);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle cycle so the next call never re-raises psel in the same step
      @(posedge core_clk);
      if (i == 20)
      begin
         num_errors++;
         summarize();
      end
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      seed = 32'hB9C4;
      {reset, psel, penable, pwrite, paddr, pwdata, conv_code} = {4'h8, 8'h00, 32'h0, 12'h0};
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      chk("power_en", 32'h0, 32'(ana.power_en));
      apb(1'b0, CF, 32'h0);
      chk("ctrl_first", 32'h20, rd);
      apb(1'b0, 8'h18, 32'h0);
      chk("slverr", 32'h1, 32'(se));
      apb(1'b1, `ADCC_INT_MASK_OFS, 32'h1);
      apb(1'b1, CF, 32'h0);
      repeat (SETTLE_CYCLES) @(posedge core_clk);
      chk("power_on", 32'h1, 32'(ana.power_en));
      for (n = 0; n < 8; n++)
      begin
         j = n[0];
         conv_code <= 12'($random(seed));
         apb(1'b1, CS, 32'(j) << 4 | 32'(n));
         apb(1'b1, `ADCC_PIN_ENABLE_OFS, 32'(conv_code[3:0]));
         chk("ref", 32'(j), 32'(ana.vref_pin_sel));
         apb(1'b1, CF, 32'h80 | 32'(j) << 4);
         apb(1'b0, CF, 32'h0);
         chk("hold", 32'hC0 | 32'(j) << 4, rd);
         apb(1'b1, CF, 32'(j) << 4);
         w = 0;
         while (irq !== 1'b1 && w < 3000)
         begin
            @(posedge core_clk);
            w++;
         end
         if (irq !== 1'b1)
         begin
            num_errors++;
            summarize();
         end
         chk("cycles", 32'(16 * (1 << (n > 6 ? 6 : n)) + 2), 32'(w));
         apb(1'b0, CF, 32'h0);
         chk("done", 32'(j) << 4, rd);
         apb(1'b0, `ADCC_RESULT_OFS, 32'h0);
         chk("result", j ? 32'(conv_code) : 32'(conv_code) << 4, rd);
         apb(1'b0, `ADCC_INT_STATUS_OFS, 32'h0);
         chk("status", 32'h1, rd);
         apb(1'b0, `ADCC_INT_STATUS_OFS, 32'h0);
         chk("cleared", 32'h0, rd);
         chk("irq", 32'h0, 32'(irq));
      end
      apb(1'b1, `ADCC_INT_MASK_OFS, 32'h0);
      apb(1'b1, CS, 32'h5);
      apb(1'b1, CF, 32'h80);
      apb(1'b1, CF, 32'h20);
      w = 0;
      do
      begin
         apb(1'b0, CF, 32'h0);
         w++;
      end
      while (rd[6] && w < 400);
      if (rd[6])
      begin
         num_errors++;
         summarize();
      end
      chk("poll", 32'h20, rd);
      chk("masked", 32'h0, 32'(irq));
      chk("power_off", 32'h0, 32'(ana.power_en));
      summarize();
   end
endmodule // tb_top
